// ==== rtl/modbus_pkg.sv ====
// Constants, types and helper functions shared by the serial slave handler and its line UART
package modbus_pkg;

	// ------------------------------------------------------------
	// Clock and line timing
	// ------------------------------------------------------------
	localparam int SYS_CLK_HZ = 50_000_000;
	// Silence of 3.5 characters of 11 bits, rounded up to whole bit times
	localparam logic [5:0] RTU_GAP_BITS = 6'd39;

	// ------------------------------------------------------------
	// Addresses, function codes, exception codes
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_BROADCAST = 8'h00;
	localparam logic [7:0] ADDR_MIN = 8'h01;
	localparam logic [7:0] ADDR_MAX = 8'hf7;
	localparam logic [7:0] FC_RD_HOLD = 8'h03;
	localparam logic [7:0] FC_RD_INPUT = 8'h04;
	localparam logic [7:0] FC_WR_SINGLE = 8'h06;
	localparam logic [7:0] FC_DIAG = 8'h08;
	localparam logic [7:0] FC_WR_MULTI = 8'h10;
	localparam logic [7:0] FC_RDWR_MULTI = 8'h17;
	localparam logic [7:0] FC_EXCEPTION = 8'h80;
	localparam logic [7:0] EX_ILLEGAL_FUNC = 8'h01;
	localparam logic [7:0] EX_ILLEGAL_ADDR = 8'h02;
	localparam logic [7:0] EX_ILLEGAL_VALUE = 8'h03;
	localparam logic [15:0] MAX_READ_QTY = 16'h007d;
	localparam logic [15:0] MAX_WRITE_QTY = 16'h007b;
	localparam logic [15:0] MAX_RW_WRITE_QTY = 16'h0079;

	// ------------------------------------------------------------
	// Framing and buffer
	// ------------------------------------------------------------
	localparam logic [8:0] BUF_DEPTH = 9'd256;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [7:0] ASCII_START = 8'h3a;
	localparam logic [7:0] ASCII_CR = 8'h0d;
	localparam logic [7:0] ASCII_LF = 8'h0a;

	typedef enum logic [3:0] {
		S_RX, S_CHECK, S_DECODE, S_WRITE, S_WRITE_WAIT, S_READ, S_READ_WAIT,
		S_TX_HEAD, S_TX_DATA, S_TX_TAIL, S_TX_DRAIN
	} slave_state_t;

	function automatic int baud_rate(input logic [2:0] sel);
		case (sel)
			3'h0: baud_rate = 1200;
			3'h1: baud_rate = 2400;
			3'h2: baud_rate = 4800;
			3'h3: baud_rate = 9600;
			3'h4: baud_rate = 19200;
			3'h5: baud_rate = 38400;
			3'h6: baud_rate = 57600;
			default: baud_rate = 115200;
		endcase
	endfunction : baud_rate

	function automatic logic [15:0] crc16_step(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		crc16_step = c;
	endfunction : crc16_step

	// Bit 4 flags a valid hex digit
	function automatic logic [4:0] hex_val(input logic [7:0] ch);
		if (ch >= 8'h30 && ch <= 8'h39) begin
			hex_val = {1'b1, 4'(ch - 8'h30)};
		end else if (ch >= 8'h41 && ch <= 8'h46) begin
			hex_val = {1'b1, 4'(ch - 8'h37)};
		end else begin
			hex_val = 5'h00;
		end
	endfunction : hex_val

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		hex_char = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction : hex_char

endpackage : modbus_pkg

// ==== rtl/modbus_uart.sv ====
// Half-duplex 8N1 line UART with selectable rate and a free bit-time tick
`timescale 1ns/10ps
module modbus_uart import modbus_pkg::*; #(
	parameter int CLK_HZ = SYS_CLK_HZ
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [2:0] baud_sel,
	input wire logic rx_pin,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic bit_tick,
	input wire logic [7:0] tx_data,
	input wire logic tx_start,
	output logic tx_ready,
	output logic tx_pin
);

	logic [31:0] div;
	logic s1, s2, s3, line, next_line;
	logic [31:0] tk, next_tk, rx_cnt, next_rx_cnt, tx_cnt, next_tx_cnt;
	logic rx_busy, next_rx_busy, tx_busy, next_tx_busy, next_rx_valid, next_tick, next_tx_pin;
	logic [3:0] rx_bit, next_rx_bit, tx_bit, next_tx_bit;
	logic [7:0] rx_sh, next_rx_sh;
	logic [9:0] tx_sh, next_tx_sh;

	assign div = 32'(CLK_HZ / baud_rate(baud_sel));
	assign tx_ready = ~tx_busy & ~tx_start;
	assign rx_data = rx_sh;

	always_comb begin
		next_line = (s2 == s3) ? s3 : line;
		next_tick = 1'b0;
		next_tk = tk + 32'd1;
		if (tk >= div - 32'd1) begin
			next_tk = 32'd0;
			next_tick = 1'b1;
		end
		next_rx_busy = rx_busy;
		next_rx_cnt = rx_cnt;
		next_rx_bit = rx_bit;
		next_rx_sh = rx_sh;
		next_rx_valid = 1'b0;
		if (!rx_busy) begin
			if (!line) begin
				next_rx_busy = 1'b1;
				next_rx_cnt = div >> 1;
				next_rx_bit = 4'h0;
			end
		end else if (rx_cnt == 32'd0) begin
			next_rx_cnt = div - 32'd1;
			next_rx_bit = rx_bit + 4'h1;
			if (rx_bit == 4'h0) begin
				next_rx_busy = ~line;
			end else if (rx_bit == 4'h9) begin
				next_rx_busy = 1'b0;
				next_rx_valid = line;
			end else begin
				next_rx_sh = {line, rx_sh[7:1]};
			end
		end else begin
			next_rx_cnt = rx_cnt - 32'd1;
		end
		next_tx_busy = tx_busy;
		next_tx_cnt = tx_cnt;
		next_tx_bit = tx_bit;
		next_tx_sh = tx_sh;
		next_tx_pin = tx_pin;
		if (!tx_busy) begin
			if (tx_start) begin
				next_tx_busy = 1'b1;
				next_tx_sh = {1'b1, tx_data, 1'b0};
				next_tx_pin = 1'b0;
				next_tx_cnt = div - 32'd1;
				next_tx_bit = 4'h0;
			end
		end else if (tx_cnt == 32'd0) begin
			next_tx_cnt = div - 32'd1;
			if (tx_bit == 4'h9) begin
				next_tx_busy = 1'b0;
			end else begin
				next_tx_sh = {1'b1, tx_sh[9:1]};
				next_tx_pin = tx_sh[1];
				next_tx_bit = tx_bit + 4'h1;
			end
		end else begin
			next_tx_cnt = tx_cnt - 32'd1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
			line <= 1'b1;
			tk <= 32'd0;
			bit_tick <= 1'b0;
			rx_busy <= 1'b0;
			rx_cnt <= 32'd0;
			rx_bit <= 4'h0;
			rx_sh <= 8'h00;
			rx_valid <= 1'b0;
			tx_busy <= 1'b0;
			tx_cnt <= 32'd0;
			tx_bit <= 4'h0;
			tx_sh <= 10'h3ff;
			tx_pin <= 1'b1;
		end else begin
			s1 <= rx_pin;
			s2 <= s1;
			s3 <= s2;
			line <= next_line;
			tk <= next_tk;
			bit_tick <= next_tick;
			rx_busy <= next_rx_busy;
			rx_cnt <= next_rx_cnt;
			rx_bit <= next_rx_bit;
			rx_sh <= next_rx_sh;
			rx_valid <= next_rx_valid;
			tx_busy <= next_tx_busy;
			tx_cnt <= next_tx_cnt;
			tx_bit <= next_tx_bit;
			tx_sh <= next_tx_sh;
			tx_pin <= next_tx_pin;
		end
	end

endmodule : modbus_uart

// ==== rtl/modbus_serial_slave_handler.sv ====
// Serial-line slave: frame reception, request decode, parameter access and response
`timescale 1ns/10ps
module modbus_serial_slave_handler import modbus_pkg::*; #(
	parameter int CLK_HZ = SYS_CLK_HZ
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic rx_pin,
	output logic tx_pin,
	output logic tx_drive_en,
	input wire logic [7:0] slave_addr,
	input wire logic [2:0] baud_sel,
	input wire logic ascii_mode,
	output logic [15:0] param_addr,
	output logic [15:0] param_wdata,
	output logic param_rd,
	output logic param_wr,
	output logic param_input_space,
	input wire logic [15:0] param_rdata,
	input wire logic param_ack,
	input wire logic param_err,
	output logic frame_error
);

	logic [7:0] rx_buf [0:255];
	logic [7:0] tx_buf [0:255];
	logic [7:0] rx_data, tx_char, next_tx_char, resp_fc, next_resp_fc, resp_b2, next_resp_b2;
	logic rx_valid, bit_tick, tx_ready, tx_start, next_tx_start;
	slave_state_t state, next_state;
	logic [8:0] rx_len, next_rx_len, tx_len, next_tx_len, echo_len, next_echo_len;
	logic [8:0] tx_pos, next_tx_pos, pay_len;
	logic [5:0] gap, next_gap;
	logic [15:0] crc, next_crc, tx_crc, next_tx_crc;
	logic [15:0] w_addr, next_w_addr, r_addr, next_r_addr, w_cnt, next_w_cnt, r_cnt, next_r_cnt;
	logic [15:0] f_w2, f_w4, f_w6, f_w8;
	logic [7:0] lrc, next_lrc, tx_lrc, next_tx_lrc, w_idx, next_w_idx;
	logic [3:0] hi_nib, next_hi_nib;
	logic nib_half, next_nib_half, in_frame, next_in_frame, tx_nib, next_tx_nib;
	logic tail, next_tail, broadcast, next_broadcast, next_drive, next_frame_error;
	logic [15:0] next_param_addr, next_param_wdata;
	logic next_param_rd, next_param_wr, next_param_input_space;
	logic rx_we, tx_we;
	logic [7:0] rx_wd, msg_byte, cur_byte;

	modbus_uart #(.CLK_HZ(CLK_HZ)) line_uart (
		.clk(clk),
		.reset_n(reset_n),
		.baud_sel(baud_sel),
		.rx_pin(rx_pin),
		.rx_data(rx_data),
		.rx_valid(rx_valid),
		.bit_tick(bit_tick),
		.tx_data(tx_char),
		.tx_start(tx_start),
		.tx_ready(tx_ready),
		.tx_pin(tx_pin)
	);

	assign f_w2 = {rx_buf[2], rx_buf[3]};
	assign f_w4 = {rx_buf[4], rx_buf[5]};
	assign f_w6 = {rx_buf[6], rx_buf[7]};
	assign f_w8 = {rx_buf[8], rx_buf[9]};
	assign pay_len = ascii_mode ? rx_len - 9'd1 : rx_len - 9'd2;

	// Response bytes come from the request itself where it is echoed
	always_comb begin
		if (tx_pos < echo_len) begin
			msg_byte = rx_buf[tx_pos[7:0]];
		end else if (tx_pos == 9'd0) begin
			msg_byte = rx_buf[0];
		end else if (tx_pos == 9'd1) begin
			msg_byte = resp_fc;
		end else if (tx_pos == 9'd2) begin
			msg_byte = resp_b2;
		end else begin
			msg_byte = tx_buf[tx_pos[7:0]];
		end
		if (tx_pos < tx_len) begin
			cur_byte = msg_byte;
		end else if (ascii_mode) begin
			cur_byte = 8'h00 - tx_lrc;
		end else begin
			cur_byte = (tx_pos == tx_len) ? tx_crc[7:0] : tx_crc[15:8];
		end
	end

	// ------------------------------------------------------------
	// Control sequence
	// ------------------------------------------------------------
	always_comb begin
		logic [4:0] hv;
		logic rearm, ex, ok, own;
		logic [7:0] ex_code;
		hv = hex_val(rx_data);
		rearm = 1'b0;
		ex = 1'b0;
		ok = 1'b0;
		own = 1'b0;
		ex_code = EX_ILLEGAL_FUNC;
		next_state = state;
		next_rx_len = rx_len;
		next_gap = gap;
		next_crc = crc;
		next_lrc = lrc;
		next_hi_nib = hi_nib;
		next_nib_half = nib_half;
		next_in_frame = in_frame;
		next_tx_len = tx_len;
		next_echo_len = echo_len;
		next_tx_pos = tx_pos;
		next_tx_nib = tx_nib;
		next_tx_crc = tx_crc;
		next_tx_lrc = tx_lrc;
		next_tail = tail;
		next_broadcast = broadcast;
		next_resp_fc = resp_fc;
		next_resp_b2 = resp_b2;
		next_w_addr = w_addr;
		next_w_cnt = w_cnt;
		next_w_idx = w_idx;
		next_r_addr = r_addr;
		next_r_cnt = r_cnt;
		next_param_addr = param_addr;
		next_param_wdata = param_wdata;
		next_param_input_space = param_input_space;
		next_param_rd = 1'b0;
		next_param_wr = 1'b0;
		next_tx_start = 1'b0;
		next_tx_char = tx_char;
		next_drive = tx_drive_en;
		next_frame_error = 1'b0;
		rx_we = 1'b0;
		rx_wd = rx_data;
		tx_we = 1'b0;
		case (state)
			S_RX: begin
				if (rx_valid && ascii_mode) begin
					if (rx_data == ASCII_START) begin
						next_rx_len = 9'd0;
						next_lrc = 8'h00;
						next_in_frame = 1'b1;
						next_nib_half = 1'b0;
					end else if (in_frame && rx_data == ASCII_LF) begin
						next_in_frame = 1'b0;
						next_state = S_CHECK;
					end else if (in_frame && hv[4]) begin
						next_hi_nib = hv[3:0];
						next_nib_half = ~nib_half;
						if (nib_half) begin
							rx_wd = {hi_nib, hv[3:0]};
							rx_we = (rx_len < BUF_DEPTH);
							next_lrc = lrc + rx_wd;
						end
					end
				end else if (rx_valid) begin
					rx_we = (rx_len < BUF_DEPTH);
					next_crc = crc16_step(crc, rx_data);
					next_gap = 6'd0;
				end else if (!ascii_mode && bit_tick && rx_len != 9'd0) begin
					// End of an RTU frame is a silence, not a character
					if (gap == RTU_GAP_BITS - 6'd1) begin
						next_state = S_CHECK;
					end else begin
						next_gap = gap + 6'd1;
					end
				end
				if (rx_we) begin
					next_rx_len = rx_len + 9'd1;
				end
			end
			S_CHECK: begin
				ok = ascii_mode ? (rx_len >= 9'd3 && lrc == 8'h00) : (rx_len >= 9'd4 && crc == 16'h0000);
				next_frame_error = ~ok;
				rearm = ~ok;
				next_state = S_DECODE;
			end
			S_DECODE: begin
				own = (rx_buf[0] == slave_addr) && (slave_addr >= ADDR_MIN) && (slave_addr <= ADDR_MAX);
				next_broadcast = (rx_buf[0] == ADDR_BROADCAST);
				next_resp_fc = rx_buf[1];
				next_tx_len = 9'd3;
				next_echo_len = 9'd0;
				next_w_cnt = 16'h0000;
				next_r_cnt = 16'h0000;
				next_tx_pos = 9'd0;
				next_tx_nib = 1'b0;
				next_tx_crc = CRC_INIT;
				next_tx_lrc = 8'h00;
				next_tail = 1'b0;
				if (!own && !next_broadcast) begin
					rearm = 1'b1;
				end else begin
					case (rx_buf[1])
						FC_RD_HOLD, FC_RD_INPUT: begin
							ex_code = EX_ILLEGAL_VALUE;
							ex = (f_w4 == 16'h0000) || (f_w4 > MAX_READ_QTY);
							next_r_addr = f_w2;
							next_r_cnt = f_w4;
							next_resp_b2 = {f_w4[6:0], 1'b0};
							next_param_input_space = (rx_buf[1] == FC_RD_INPUT);
							next_state = S_READ;
						end
						FC_DIAG: begin
							next_echo_len = pay_len;
							next_tx_len = pay_len;
							next_state = S_TX_HEAD;
						end
						FC_WR_SINGLE: begin
							next_w_addr = f_w2;
							next_w_idx = 8'd4;
							next_w_cnt = 16'h0001;
							next_echo_len = 9'd6;
							next_tx_len = 9'd6;
							next_state = S_WRITE;
						end
						FC_WR_MULTI: begin
							ex_code = EX_ILLEGAL_VALUE;
							ex = (f_w4 == 16'h0000) || (f_w4 > MAX_WRITE_QTY) ||
								(rx_buf[6] != {f_w4[6:0], 1'b0});
							next_w_addr = f_w2;
							next_w_idx = 8'd7;
							next_w_cnt = f_w4;
							next_echo_len = 9'd6;
							next_tx_len = 9'd6;
							next_state = S_WRITE;
						end
						FC_RDWR_MULTI: begin
							ex_code = EX_ILLEGAL_VALUE;
							ex = (f_w4 == 16'h0000) || (f_w4 > MAX_READ_QTY) ||
								(f_w8 == 16'h0000) || (f_w8 > MAX_RW_WRITE_QTY) ||
								(rx_buf[10] != {f_w8[6:0], 1'b0});
							next_r_addr = f_w2;
							next_r_cnt = f_w4;
							next_w_addr = f_w6;
							next_w_cnt = f_w8;
							next_w_idx = 8'd11;
							next_resp_b2 = {f_w4[6:0], 1'b0};
							next_param_input_space = 1'b0;
							next_state = S_WRITE;
						end
						default: begin
							ex = 1'b1;
						end
					endcase
					// Broadcast acts only on the three write codes
					if (next_broadcast && !(rx_buf[1] == FC_WR_SINGLE ||
						rx_buf[1] == FC_WR_MULTI || rx_buf[1] == FC_RDWR_MULTI)) begin
						rearm = 1'b1;
						ex = 1'b0;
					end
				end
			end
			S_WRITE: begin
				next_param_addr = w_addr;
				next_param_wdata = {rx_buf[w_idx], rx_buf[8'(w_idx + 8'd1)]};
				next_param_wr = 1'b1;
				next_state = S_WRITE_WAIT;
			end
			S_WRITE_WAIT: begin
				if (param_ack && param_err) begin
					ex = 1'b1;
					ex_code = EX_ILLEGAL_ADDR;
				end else if (param_ack) begin
					next_w_addr = w_addr + 16'h0001;
					next_w_idx = w_idx + 8'd2;
					next_w_cnt = w_cnt - 16'h0001;
					if (w_cnt != 16'h0001) begin
						next_state = S_WRITE;
					end else if (r_cnt != 16'h0000) begin
						next_state = S_READ;
					end else begin
						next_state = S_TX_HEAD;
					end
				end
			end
			S_READ: begin
				next_param_addr = r_addr;
				next_param_rd = 1'b1;
				next_state = S_READ_WAIT;
			end
			S_READ_WAIT: begin
				// Latency is the parameter store's: direct or buffered access
				if (param_ack && param_err) begin
					ex = 1'b1;
					ex_code = EX_ILLEGAL_ADDR;
				end else if (param_ack) begin
					tx_we = 1'b1;
					next_tx_len = tx_len + 9'd2;
					next_r_addr = r_addr + 16'h0001;
					next_r_cnt = r_cnt - 16'h0001;
					next_state = (r_cnt == 16'h0001) ? S_TX_HEAD : S_READ;
				end
			end
			S_TX_HEAD: begin
				if (broadcast) begin
					rearm = 1'b1;
				end else if (!ascii_mode) begin
					next_drive = 1'b1;
					next_state = S_TX_DATA;
				end else if (tx_ready) begin
					next_drive = 1'b1;
					next_tx_char = ASCII_START;
					next_tx_start = 1'b1;
					next_state = S_TX_DATA;
				end
			end
			S_TX_DATA: begin
				if (tx_ready) begin
					next_tx_start = 1'b1;
					if (!ascii_mode) begin
						next_tx_char = cur_byte;
						next_tx_crc = (tx_pos < tx_len) ? crc16_step(tx_crc, cur_byte) : tx_crc;
						next_tx_pos = tx_pos + 9'd1;
						next_state = (tx_pos == tx_len + 9'd1) ? S_TX_DRAIN : S_TX_DATA;
					end else begin
						next_tx_char = hex_char(tx_nib ? cur_byte[3:0] : cur_byte[7:4]);
						next_tx_nib = ~tx_nib;
						if (tx_nib) begin
							next_tx_pos = tx_pos + 9'd1;
							next_tx_lrc = (tx_pos < tx_len) ? tx_lrc + cur_byte : tx_lrc;
							next_state = (tx_pos == tx_len) ? S_TX_TAIL : S_TX_DATA;
						end
					end
				end
			end
			S_TX_TAIL: begin
				if (tx_ready) begin
					next_tx_start = 1'b1;
					next_tx_char = tail ? ASCII_LF : ASCII_CR;
					next_tail = 1'b1;
					next_state = tail ? S_TX_DRAIN : S_TX_TAIL;
				end
			end
			S_TX_DRAIN: begin
				// Driver stays on until the last stop bit has left the line
				if (tx_ready) begin
					next_drive = 1'b0;
					rearm = 1'b1;
				end
			end
			default: begin
				rearm = 1'b1;
			end
		endcase
		if (ex) begin
			next_resp_fc = rx_buf[1] | FC_EXCEPTION;
			next_resp_b2 = ex_code;
			next_tx_len = 9'd3;
			next_echo_len = 9'd0;
			next_state = S_TX_HEAD;
		end
		if (rearm) begin
			next_state = S_RX;
			next_rx_len = 9'd0;
			next_crc = CRC_INIT;
			next_lrc = 8'h00;
			next_gap = 6'd0;
			next_in_frame = 1'b0;
			next_nib_half = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rx_we) begin
			rx_buf[rx_len[7:0]] <= rx_wd;
		end
		if (tx_we) begin
			tx_buf[tx_len[7:0]] <= param_rdata[15:8];
			tx_buf[8'(tx_len[7:0] + 8'd1)] <= param_rdata[7:0];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= S_RX;
			rx_len <= 9'd0;
			gap <= 6'd0;
			crc <= CRC_INIT;
			lrc <= 8'h00;
			hi_nib <= 4'h0;
			nib_half <= 1'b0;
			in_frame <= 1'b0;
			tx_len <= 9'd0;
			echo_len <= 9'd0;
			tx_pos <= 9'd0;
			tx_nib <= 1'b0;
			tx_crc <= CRC_INIT;
			tx_lrc <= 8'h00;
			tail <= 1'b0;
			broadcast <= 1'b0;
			resp_fc <= 8'h00;
			resp_b2 <= 8'h00;
			w_addr <= 16'h0000;
			w_cnt <= 16'h0000;
			w_idx <= 8'h00;
			r_addr <= 16'h0000;
			r_cnt <= 16'h0000;
			param_addr <= 16'h0000;
			param_wdata <= 16'h0000;
			param_input_space <= 1'b0;
			param_rd <= 1'b0;
			param_wr <= 1'b0;
			tx_start <= 1'b0;
			tx_char <= 8'h00;
			tx_drive_en <= 1'b0;
			frame_error <= 1'b0;
		end else begin
			state <= next_state;
			rx_len <= next_rx_len;
			gap <= next_gap;
			crc <= next_crc;
			lrc <= next_lrc;
			hi_nib <= next_hi_nib;
			nib_half <= next_nib_half;
			in_frame <= next_in_frame;
			tx_len <= next_tx_len;
			echo_len <= next_echo_len;
			tx_pos <= next_tx_pos;
			tx_nib <= next_tx_nib;
			tx_crc <= next_tx_crc;
			tx_lrc <= next_tx_lrc;
			tail <= next_tail;
			broadcast <= next_broadcast;
			resp_fc <= next_resp_fc;
			resp_b2 <= next_resp_b2;
			w_addr <= next_w_addr;
			w_cnt <= next_w_cnt;
			w_idx <= next_w_idx;
			r_addr <= next_r_addr;
			r_cnt <= next_r_cnt;
			param_addr <= next_param_addr;
			param_wdata <= next_param_wdata;
			param_input_space <= next_param_input_space;
			param_rd <= next_param_rd;
			param_wr <= next_param_wr;
			tx_start <= next_tx_start;
			tx_char <= next_tx_char;
			tx_drive_en <= next_drive;
			frame_error <= next_frame_error;
		end
	end

endmodule : modbus_serial_slave_handler

// ==== bench/modbus_serial_slave_handler_assertions.sv ====
// Port timing checker for the serial slave handler
`timescale 1ns/10ps
module port_checker (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic tx_pin,
	input wire logic tx_drive_en,
	input wire logic [15:0] param_addr,
	input wire logic param_rd,
	input wire logic param_wr,
	input wire logic frame_error
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking dc @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_excl; !(param_rd && param_wr); endproperty
	a_excl: assert property (p_excl)
		else $error("read and write at once");
	property p_rd_pulse; param_rd |=> !param_rd; endproperty
	a_rd_pulse: assert property (p_rd_pulse)
		else $error("read strobe too long");
	property p_wr_pulse; param_wr |=> !param_wr; endproperty
	a_wr_pulse: assert property (p_wr_pulse)
		else $error("write strobe too long");
	property p_quiet; tx_drive_en |-> !param_rd && !param_wr; endproperty
	a_quiet: assert property (p_quiet)
		else $error("access while answering");
	property p_idle; !tx_drive_en |-> tx_pin; endproperty
	a_idle: assert property (p_idle)
		else $error("line not idle high");
	property p_ferr; frame_error |=> !frame_error; endproperty
	a_ferr: assert property (p_ferr)
		else $error("frame error too long");
	property p_start; $rose(tx_drive_en) |-> tx_pin ##[1:2] !tx_pin; endproperty
	a_start: assert property (p_start)
		else $error("start bit late");
	property p_release; $fell(tx_drive_en) |-> tx_pin && $past(tx_pin); endproperty
	a_release: assert property (p_release)
		else $error("driver off before stop bit");
	property p_addr_hold; $changed(param_addr) |-> param_rd || param_wr; endproperty
	a_addr_hold: assert property (p_addr_hold)
		else $error("address moved without access");
	c_reply: cover property ($rose(tx_drive_en));
	c_write: cover property (param_wr);
	c_ferr: cover property (frame_error);
endmodule : port_checker

// ==== bench/modbus_master_model.sv ====
// Behavioural bus master: sends request bytes, collects response bytes
`timescale 1ns/10ps
module modbus_master_model (
	input wire logic clk,
	input wire logic [7:0] bit_cyc,
	input wire logic tx_pin,
	input wire logic tx_drive_en,
	output logic rx_pin,
	output logic [7:0] rsp_byte,
	output logic rsp_stb
);
	logic line;
	// Biased line reads high while the slave's driver is off
	assign line = tx_drive_en ? tx_pin : 1'b1;
	initial begin
		rx_pin = 1'b1;
		rsp_byte = 8'h00;
		rsp_stb = 1'b0;
	end
	// 8N1, low bit first, at the shared rate
	task automatic send_byte(input logic [7:0] v);
		for (int i = 0; i < 10; i++) begin
			rx_pin <= (i == 0) ? 1'b0 : ((i == 9) ? 1'b1 : v[i - 1]);
			repeat (bit_cyc) @(posedge clk);
		end
	endtask : send_byte
	always begin
		@(negedge line);
		repeat (bit_cyc * 3 / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			rsp_byte[i] <= line;
			repeat (bit_cyc) @(posedge clk);
		end
		rsp_stb <= 1'b1;
		@(posedge clk);
		rsp_stb <= 1'b0;
	end
endmodule : modbus_master_model

// ==== bench/modbus_serial_slave_handler_tb.sv ====
// Self-checking bench for the serial slave handler
`timescale 1ns/10ps
module modbus_serial_slave_handler_tb;
	localparam logic [7:0] S = 8'h2c;
	localparam logic [15:0] K = 16'h5a5a;
	typedef logic [7:0] bytes_t[$];
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic rx_pin, tx_pin, tx_drive_en, param_rd, param_wr, param_input_space, frame_error;
	logic [15:0] param_addr, param_wdata, a, b, d, x;
	logic [15:0] param_rdata = 16'h0000;
	logic param_ack = 1'b0;
	logic param_err = 1'b0;
	logic sp = 1'b0;
	logic bad = 1'b0;
	logic [7:0] rsp_byte;
	logic rsp_stb;
	logic [31:0] seed = 32'h39d6;
	logic [7:0] q[$], r[$], expq[$];
	logic [31:0] wlog[$];
	int failures, num_checks, nrd, nfe;
	logic ascii = 1'b0;
	logic [2:0] baud = 3'h7;
	logic [7:0] cyc = 8'h0a;
	always #10 clk = ~clk;
	modbus_serial_slave_handler #(.CLK_HZ(1_152_000)) DUT (.clk(clk), .reset_n(reset_n),
		.rx_pin(rx_pin), .tx_pin(tx_pin), .tx_drive_en(tx_drive_en), .slave_addr(S),
		.baud_sel(baud), .ascii_mode(ascii), .param_addr(param_addr),
		.param_wdata(param_wdata), .param_rd(param_rd), .param_wr(param_wr),
		.param_input_space(param_input_space), .param_rdata(param_rdata),
		.param_ack(param_ack), .param_err(param_err), .frame_error(frame_error));
	modbus_master_model mm (.clk(clk), .bit_cyc(cyc), .tx_pin(tx_pin),
		.tx_drive_en(tx_drive_en), .rx_pin(rx_pin), .rsp_byte(rsp_byte), .rsp_stb(rsp_stb));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction : rnd
	function automatic logic [15:0] crc(input logic [7:0] v[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (v[i]) begin
			c = c ^ {8'h00, v[i]};
			repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		end
		return c;
	endfunction : crc
	// Colon, two upper-case hex digits a byte, check byte, CR LF
	function automatic bytes_t asc(input logic [7:0] v[$]);
		logic [7:0] s;
		logic [3:0] h;
		bytes_t o;
		s = 8'h00;
		o = {8'h3a};
		foreach (v[i]) s = s - v[i];
		v.push_back(s);
		foreach (v[i]) begin
			for (int k = 1; k >= 0; k--) begin
				h = v[i][4 * k +: 4];
				o.push_back((h < 4'ha) ? 8'h30 + h : 8'h37 + h);
			end
		end
		o.push_back(8'h0d);
		o.push_back(8'h0a);
		return o;
	endfunction : asc
	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (!ok) begin
			failures++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic test_done();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done
	// Sends q with its check, queues r as the reply and waits for the line to go quiet
	task automatic frame();
		logic [15:0] c;
		int n;
		c = crc(q);
		if (ascii) begin
			q = asc(q);
			if (r.size() > 0)
				r = asc(r);
		end else begin
			q.push_back(c[7:0] ^ {7'h00, bad});
			q.push_back(c[15:8]);
			if (r.size() > 0) begin
				c = crc(r);
				r.push_back(c[7:0]);
				r.push_back(c[15:8]);
			end
		end
		foreach (r[i]) expq.push_back(r[i]);
		foreach (q[i]) mm.send_byte(q[i]);
		n = 0;
		repeat (420) @(posedge clk);
		while ((expq.size() > 0 || tx_drive_en !== 1'b0) && n < 30000) begin
			@(posedge clk);
			n++;
		end
		chk(n < 30000, "no reply");
	endtask : frame
	// ------------------------------------------------------------
	// Parameter store and reply monitor
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (frame_error)
			nfe++;
		if (param_rd || param_wr) begin
			if (param_rd)
				nrd++;
			if (param_rd)
				chk(param_input_space === sp, "space");
			if (param_wr)
				wlog.push_back({param_addr, param_wdata});
			repeat (rnd() % 4) @(posedge clk);
			#1;
			param_rdata = param_addr ^ K;
			param_err = param_addr[15:12] == 4'hf;
			param_ack = 1'b1;
			@(posedge clk);
			#1;
			param_ack = 1'b0;
		end
	end
	always @(posedge rsp_stb) begin
		if (expq.size() == 0)
			chk(1'b0, "unexpected reply");
		else
			chk(rsp_byte === expq.pop_front(), "reply byte");
	end
	initial begin
		repeat (80000) @(posedge clk);
		failures++;
		test_done();
	end
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		#1;
		reset_n = 1'b1;
		repeat (5) @(posedge clk);
		a = rnd() & 16'h0ffe;
		d = a ^ K;
		b = (a + 16'h1) ^ K;
		q = {S, 8'h03, a[15:8], a[7:0], 8'h00, 8'h02};
		r = {S, 8'h03, 8'h04, d[15:8], d[7:0], b[15:8], b[7:0]};
		frame();
		sp = 1'b1;
		q = {S, 8'h04, a[15:8], a[7:0], 8'h00, 8'h01};
		r = {S, 8'h04, 8'h02, d[15:8], d[7:0]};
		frame();
		sp = 1'b0;
		d = rnd();
		// Top nibble f is an unmapped address in the store model
		b = rnd() & 16'h0fff;
		q = {S, 8'h08, 8'h00, 8'h00, d[15:8], d[7:0]};
		r = q;
		frame();
		q = {S, 8'h06, a[15:8], a[7:0], d[15:8], d[7:0]};
		r = q;
		frame();
		chk(wlog.size() == 1 && wlog[0] === {a, d}, "single write");
		q = {S, 8'h10, a[15:8], a[7:0], 8'h00, 8'h02, 8'h04, d[15:8], d[7:0], b[15:8], b[7:0]};
		r = {S, 8'h10, a[15:8], a[7:0], 8'h00, 8'h02};
		frame();
		chk(wlog.size() == 3 && wlog[2] === {a + 16'h1, b}, "block write");
		x = a ^ K;
		q = {S, 8'h17, a[15:8], a[7:0], 8'h00, 8'h01, b[15:8], b[7:0], 8'h00, 8'h01, 8'h02,
			d[15:8], d[7:0]};
		r = {S, 8'h17, 8'h02, x[15:8], x[7:0]};
		frame();
		chk(wlog.size() == 4 && wlog[3] === {b, d}, "combined write");
		q = {8'h00, 8'h06, b[15:8], b[7:0], d[15:8], d[7:0]};
		r.delete();
		frame();
		chk(wlog.size() == 5 && wlog[4] === {b, d}, "broadcast write");
		nrd = 0;
		q = {8'h00, 8'h03, a[15:8], a[7:0], 8'h00, 8'h01};
		frame();
		q = {S ^ 8'h01, 8'h03, a[15:8], a[7:0], 8'h00, 8'h01};
		frame();
		chk(nrd == 0, "read not for us");
		q = {S, 8'h05, a[15:8], a[7:0], 8'hff, 8'h00};
		r = {S, 8'h85, 8'h01};
		frame();
		q = {S, 8'h03, 8'hf0, 8'h00, 8'h00, 8'h01};
		r = {S, 8'h83, 8'h02};
		frame();
		bad = 1'b1;
		q = {S, 8'h08, 8'h00, 8'h00, d[15:8], d[7:0]};
		r.delete();
		frame();
		chk(nfe == 1, "check failure flag");
		// Text framing at a slower rate, switched between frames
		#1;
		ascii = 1'b1;
		baud = 3'h6;
		cyc = 8'h14;
		bad = 1'b0;
		q = {S, 8'h08, 8'h00, 8'h00, d[15:8], d[7:0]};
		r = q;
		frame();
		test_done();
	end
endmodule : modbus_serial_slave_handler_tb
bind modbus_serial_slave_handler port_checker chk_i (.clk(clk), .reset_n(reset_n),
	.tx_pin(tx_pin), .tx_drive_en(tx_drive_en), .param_addr(param_addr),
	.param_rd(param_rd), .param_wr(param_wr), .frame_error(frame_error));
